/* File: dgrp_consts.svh */
// Timing counts and field positions for the gear-down/refresh block
// Assumes a 50 MHz command clock
`ifndef DGRP_CONSTS_SVH
`define DGRP_CONSTS_SVH
`define DGRP_CLK_PERIOD_PS      20000
`define DGRP_PAR_EXIT_NS        6
`define DGRP_PAR_EXIT_CK_MIN    4
`define DGRP_PAR_EXIT_CYC  ((`DGRP_PAR_EXIT_NS*1000+`DGRP_CLK_PERIOD_PS-1)/`DGRP_CLK_PERIOD_PS)
`define DGRP_GEARDOWN_BIT       3
`define DGRP_SR_ABORT_BIT       9
`define DGRP_SYNC_GEAR_CYC      8
`define DGRP_CMD_GEAR_CYC       8
`define DGRP_RFC_CYC            18
`define DGRP_ROW_W              16
`endif

/* File: dgrp_core.sv */
// Command-side control: gear-down, refresh, parity power-down exit
// Assumes commands arrive already sampled on ref_clk_in
//
// Operation
// - Quarter-rate mode chosen by mode_reg_three bit 3, at init/exit only
// - Device starts in half-rate mode without any write or sync
// - Initialization continues quarter-rate after command-gear delay
// - Self refresh returns device to half-rate; exit delay precedes write
// - Exit delay is normal when mode_reg_four bit 9 clear, abort if set
// - Refresh decoded from CS, RAS, CAS low and WE, ACT high
// - Rows come from an internal counter; banks left idle afterwards
`timescale 1ns/100ps
`default_nettype none
`include "dgrp_consts.svh"
module dgrp_core #(
  parameter int ROW_W = `DGRP_ROW_W,
  parameter int RFC_CYC = `DGRP_RFC_CYC
) (
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  input  wire logic             cs_n_in,
  input  wire logic             act_n_in,
  input  wire logic             ras_n_in,
  input  wire logic             cas_n_in,
  input  wire logic             we_n_in,
  input  wire logic             cke_in,
  input  wire logic             mrs_three_in,
  input  wire logic [13:0]      mrs_data_in,
  input  wire logic             self_refresh_in,
  input  wire logic             sr_abort_in,
  input  wire logic             parity_en_in,
  input  wire logic [3:0]       parity_latency_in,
  output logic                  quarter_rate_out,
  output logic                  gear_busy_out,
  output logic                  refresh_busy_out,
  output logic [ROW_W-1:0]      refresh_row_out,
  output logic                  banks_idle_out,
  output logic                  pd_exit_busy_out,
  output logic                  exit_abort_out
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [6:0] in_m_r, in_s_r;
  always_ff @(posedge ref_clk_in) begin
    in_m_r <= {cs_n_in, act_n_in, ras_n_in, cas_n_in, we_n_in,
               cke_in, self_refresh_in};
    in_s_r <= in_m_r;
  end
  logic cs_n, act_n, ras_n, cas_n, we_n, cke, sr;
  assign {cs_n, act_n, ras_n, cas_n, we_n, cke, sr} = in_s_r;

  // ----------------------------------------------------------------
  // Refresh decode and cycle
  // ----------------------------------------------------------------
  function automatic logic is_refresh(input logic c, a, r, s, w);
    is_refresh = !c && a && !r && !s && w;
  endfunction
  logic ref_cmd;
  assign ref_cmd = is_refresh(cs_n, act_n, ras_n, cas_n, we_n);

  logic [7:0]       rfc_r, rfc_nxt;
  logic [ROW_W-1:0] row_r, row_nxt;
  always_comb begin
    rfc_nxt = rfc_r;
    row_nxt = row_r;
    if (ref_cmd && rfc_r == 8'h00) begin
      rfc_nxt = 8'(RFC_CYC);
      row_nxt = row_r + 1'b1;
    end else if (rfc_r != 8'h00) begin
      rfc_nxt = rfc_r - 8'h01;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rfc_r <= 8'h00;
      row_r <= '0;
    end else begin
      rfc_r <= rfc_nxt;
      row_r <= row_nxt;
    end
  end
  assign refresh_busy_out = (rfc_r != 8'h00);
  assign refresh_row_out  = row_r;
  assign banks_idle_out   = (rfc_r == 8'h00);

  // ----------------------------------------------------------------
  // Gear-down control
  // ----------------------------------------------------------------
  dgrp_pkg::dgrp_gear_e gear_r, gear_nxt;
  logic [7:0] gcnt_r, gcnt_nxt;
  logic       sr_d_r, sr_d_nxt, allow_r, allow_nxt, abort_r, abort_nxt;
  logic       sync_pulse;
  assign sync_pulse = !cs_n && act_n && ras_n && cas_n && we_n;
  always_comb begin
    gear_nxt  = gear_r;
    gcnt_nxt  = gcnt_r + 8'h01;
    sr_d_nxt  = sr;
    allow_nxt = allow_r;
    abort_nxt = abort_r;
    if (sr && !sr_d_r) allow_nxt = 1'b0;
    if (!sr && sr_d_r) allow_nxt = 1'b1;
    // Exit delay select follows mode_reg_four abort bit
    abort_nxt = sr_abort_in;
    if (sr) begin
      gear_nxt = dgrp_pkg::DGRP_HALF;
    end else begin
      case (gear_r)
        dgrp_pkg::DGRP_HALF: begin
          if (mrs_three_in && allow_r &&
              mrs_data_in[`DGRP_GEARDOWN_BIT]) begin
            gear_nxt = dgrp_pkg::DGRP_WAIT_SYNC;
            gcnt_nxt = 8'h01;
          end
        end
        dgrp_pkg::DGRP_WAIT_SYNC: begin
          if (sync_pulse && !gcnt_r[0]) begin
            gear_nxt = dgrp_pkg::DGRP_SYNC_GEAR;
            gcnt_nxt = 8'h00;
          end
        end
        dgrp_pkg::DGRP_SYNC_GEAR: begin
          if (gcnt_r == 8'(`DGRP_SYNC_GEAR_CYC - 1)) begin
            gear_nxt = dgrp_pkg::DGRP_CMD_GEAR;
            gcnt_nxt = 8'h00;
          end
        end
        dgrp_pkg::DGRP_CMD_GEAR: begin
          if (gcnt_r == 8'(`DGRP_CMD_GEAR_CYC - 1)) begin
            gear_nxt  = dgrp_pkg::DGRP_QUARTER;
            allow_nxt = 1'b0;
          end
        end
        dgrp_pkg::DGRP_QUARTER: begin
          gear_nxt = dgrp_pkg::DGRP_QUARTER;
        end
        default: gear_nxt = dgrp_pkg::DGRP_HALF;
      endcase
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      gear_r  <= dgrp_pkg::DGRP_HALF;
      gcnt_r  <= 8'h00;
      sr_d_r  <= 1'b0;
      allow_r <= 1'b1;
      abort_r <= 1'b0;
    end else begin
      gear_r  <= gear_nxt;
      gcnt_r  <= gcnt_nxt;
      sr_d_r  <= sr_d_nxt;
      allow_r <= allow_nxt;
      abort_r <= abort_nxt;
    end
  end
  assign quarter_rate_out = (gear_r == dgrp_pkg::DGRP_QUARTER);
  assign gear_busy_out    = (gear_r == dgrp_pkg::DGRP_SYNC_GEAR) ||
                            (gear_r == dgrp_pkg::DGRP_CMD_GEAR);
  assign exit_abort_out   = abort_r;

  // ----------------------------------------------------------------
  // Power-down exit with parity
  // ----------------------------------------------------------------
  localparam int PAR_BASE = (`DGRP_PAR_EXIT_CYC > `DGRP_PAR_EXIT_CK_MIN) ?
                            `DGRP_PAR_EXIT_CYC : `DGRP_PAR_EXIT_CK_MIN;
  logic [4:0] pd_r, pd_nxt;
  logic       cke_d_r, cke_d_nxt;
  always_comb begin
    cke_d_nxt = cke;
    pd_nxt = (pd_r != 5'h00) ? pd_r - 5'h01 : 5'h00;
    if (cke && !cke_d_r && parity_en_in)
      pd_nxt = 5'(PAR_BASE) + {1'b0, parity_latency_in};
  end
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pd_r    <= 5'h00;
      cke_d_r <= 1'b1;
    end else begin
      pd_r    <= pd_nxt;
      cke_d_r <= cke_d_nxt;
    end
  end
  assign pd_exit_busy_out = (pd_r != 5'h00);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_gear_write;
    gear_r == dgrp_pkg::DGRP_HALF && !sr && mrs_three_in && allow_r &&
    mrs_data_in[`DGRP_GEARDOWN_BIT];
  endsequence
  sequence s_sync_taken;
    gear_r == dgrp_pkg::DGRP_WAIT_SYNC && sync_pulse && !gcnt_r[0] && !sr;
  endsequence
  chk_refresh_busy_len: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    (ref_cmd && !refresh_busy_out) |=> refresh_busy_out [*8])
    else $error("refresh busy too short");
  chk_row_advance: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    (ref_cmd && !refresh_busy_out) |=> refresh_row_out ==
      $past(refresh_row_out) + 1'b1)
    else $error("refresh row not advanced");
  chk_reset_half_rate: assert property (@(posedge ref_clk_in)
    $past(reset_in) |-> !quarter_rate_out && !gear_busy_out)
    else $error("not half rate after reset");
  chk_sr_half_rate: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) sr |=> !quarter_rate_out)
    else $error("quarter rate kept in self refresh");
  chk_gear_entry: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    s_gear_write |=> gear_r == dgrp_pkg::DGRP_WAIT_SYNC)
    else $error("gear-down write ignored");
  chk_sync_gear_len: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    s_sync_taken |=> gear_busy_out [*8] ##1 gear_busy_out)
    else $error("sync gear period wrong");
  chk_even_sync: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    (gear_r == dgrp_pkg::DGRP_WAIT_SYNC && sync_pulse && gcnt_r[0] && !sr)
      |=> gear_r == dgrp_pkg::DGRP_WAIT_SYNC)
    else $error("odd sync pulse accepted");
  chk_pd_exit_wait: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    (cke && !cke_d_r && parity_en_in) |=> pd_exit_busy_out [*4])
    else $error("parity exit wait too short");
  chk_abort_select: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    1'b1 |=> exit_abort_out == $past(sr_abort_in))
    else $error("exit delay select wrong");
endmodule
`default_nettype wire

/* File: dgrp_ctrl_model.sv */
// Controller model: drives the command pins of the block
// Assumes the bench calls issue() and that pins idle as deselect
`timescale 1ns/100ps
`default_nettype none
module dgrp_ctrl_model (
  input  wire logic ref_clk_in,
  output logic      cs_n_out,
  output logic      act_n_out,
  output logic      ras_n_out,
  output logic      cas_n_out,
  output logic      we_n_out
);
  // ----------------------------------------
  // Command issue, deselect in between
  // ----------------------------------------
  initial begin
    {cs_n_out, act_n_out, ras_n_out, cas_n_out, we_n_out} = 5'h1F;
  end
  // One command cycle then deselect only
  // Caller may repeat a refresh inside cycle time to check it is ignored, banks not idle
  task automatic issue(input logic [4:0] pins);
    @(negedge ref_clk_in);
    {cs_n_out, act_n_out, ras_n_out, cas_n_out, we_n_out} = pins;
    @(negedge ref_clk_in);
    {cs_n_out, act_n_out, ras_n_out, cas_n_out, we_n_out} = 5'h1F;
  endtask
  // ----------------------------------------
  // Refresh debt, one owed per interval
  // ----------------------------------------
  localparam int REFRESH_INTERVAL_CYC = 256;
  int debt = 0;
  int ivl  = 0;
  always @(posedge ref_clk_in) begin : debt_track
    int d;
    d = debt;
    if (ivl == REFRESH_INTERVAL_CYC - 1) d = d + 1;
    // Pulled-in refreshes past 8 pay nothing
    if ({cs_n_out, act_n_out, ras_n_out, cas_n_out, we_n_out} == 5'h09 &&
        d > -8) d = d - 1;
    debt <= d;
    ivl  <= (ivl == REFRESH_INTERVAL_CYC - 1) ? 0 : ivl + 1;
  end
endmodule
`default_nettype wire

/* File: dgrp_pkg.sv */
// Types for the gear-down/refresh block
// Assumes dgrp_consts.svh is compiled alongside
package dgrp_pkg;
  typedef enum logic [2:0] {
    DGRP_HALF,
    DGRP_WAIT_SYNC,
    DGRP_SYNC_GEAR,
    DGRP_CMD_GEAR,
    DGRP_QUARTER
  } dgrp_gear_e;
endpackage

/* File: test_dram_geardown_refresh_pd_timing.sv */
// Testbench: refresh, gear-down and parity power-down exit
// Assumes dgrp_consts.svh and the controller model are compiled
`timescale 1ns/100ps
`default_nettype none
`include "dgrp_consts.svh"
module test_dram_geardown_refresh_pd_timing;
  logic        ref_clk_in = 1'b0, reset_in = 1'b1, cke_in = 1'b1;
  logic        mrs_three_in = 1'b0, self_refresh_in = 1'b0;
  logic        parity_en_in = 1'b0;
  logic [3:0]  parity_latency_in = 4'h0;
  logic [13:0] mrs_data_in = 14'h0000;
  wire logic   cs_n, act_n, ras_n, cas_n, we_n;
  logic        quarter, gear_busy, ref_busy, idle, pd_busy, abort;
  logic [15:0] row, old_row;
  int          failures = 0, comparisons = 0, seed = 71318, n;
  logic [13:0] d;
  logic        pe, ab = 1'b0;
  logic [3:0]  l;
  always #10 ref_clk_in = ~ref_clk_in;
  dgrp_ctrl_model u_ctrl (.ref_clk_in(ref_clk_in), .cs_n_out(cs_n),
    .act_n_out(act_n), .ras_n_out(ras_n), .cas_n_out(cas_n),
    .we_n_out(we_n));
  dgrp_core u_dut (.ref_clk_in(ref_clk_in),
    .reset_in(reset_in), .cs_n_in(cs_n), .act_n_in(act_n),
    .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .cke_in(cke_in),
    .mrs_three_in(mrs_three_in), .mrs_data_in(mrs_data_in),
    .self_refresh_in(self_refresh_in), .sr_abort_in(ab),
    .parity_en_in(parity_en_in), .parity_latency_in(parity_latency_in),
    .quarter_rate_out(quarter), .gear_busy_out(gear_busy),
    .refresh_busy_out(ref_busy), .refresh_row_out(row),
    .banks_idle_out(idle), .pd_exit_busy_out(pd_busy),
    .exit_abort_out(abort));
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  function automatic int exp_pd(input logic p, input logic [3:0] lat);
    int base;
    base = (`DGRP_PAR_EXIT_CK_MIN > `DGRP_PAR_EXIT_CYC) ?
           `DGRP_PAR_EXIT_CK_MIN : `DGRP_PAR_EXIT_CYC;
    return p ? base + lat : 0;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic end_sim;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Waits up to 8 cycles for a busy flag, then counts its high cycles
  task automatic width(input int b, output int cnt);
    int k;
    cnt = 0;
    k = 0;
    while (({pd_busy, gear_busy, ref_busy} >> b) % 2 !== 1 && k < 8) begin
      @(negedge ref_clk_in);
      k++;
    end
    while (({pd_busy, gear_busy, ref_busy} >> b) % 2 === 1) begin
      @(negedge ref_clk_in);
      cnt++;
      if (cnt > 100) begin
        failures++;
        end_sim();
      end
    end
  endtask
  task automatic gear_down(input logic en);
    d = $random(seed);
    d[3] = en;
    ab = $random(seed);
    parity_en_in = 1'b0;
    @(negedge ref_clk_in);
    {mrs_three_in, mrs_data_in} = {1'b1, d};
    @(negedge ref_clk_in);
    mrs_three_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    check(abort, ab);
    u_ctrl.issue(5'h0F);
    width(1, n);
    check(n, en ? `DGRP_SYNC_GEAR_CYC + `DGRP_CMD_GEAR_CYC : 0);
    check(quarter, en);
  endtask
  task automatic pd_exit;
    pe = $random(seed);
    l = $random(seed);
    if (quarter) l[0] = 1'b0;
    parity_en_in = pe;
    parity_latency_in = l;
    cke_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    cke_in = 1'b1;
    width(2, n);
    check(n, exp_pd(pe, l));
    repeat (20) @(negedge ref_clk_in);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge ref_clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    check({quarter, gear_busy, ref_busy, idle, row}, 32'h0001_0000);
    check({pd_busy, abort}, 2'h0);
    repeat (8) begin
      old_row = row;
      if ($random(seed) % 2 == 0) begin
        u_ctrl.issue(5'h09);
        width(0, n);
        check(n, 18);
        check({idle, row}, {1'b1, old_row + 16'h0001});
        u_ctrl.issue(5'h09);
        repeat (4) @(negedge ref_clk_in);
        u_ctrl.issue(5'h09);
        repeat (30) @(negedge ref_clk_in);
        check(row, old_row + 16'h0002);
      end else begin
        u_ctrl.issue(5'h08);
        repeat (6) @(negedge ref_clk_in);
        check({ref_busy, row}, {1'b0, old_row});
      end
    end
    repeat (3) pd_exit();
    gear_down(1'b0);
    gear_down(1'b1);
    self_refresh_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    check(quarter, 1'b0);
    self_refresh_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    old_row = row;
    u_ctrl.issue(5'h09);
    width(0, n);
    check({quarter, row}, {1'b0, old_row + 16'h0001});
    gear_down(1'b1);
    repeat (6) pd_exit();
    check(u_ctrl.debt > 8, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
